/* fts_cfg.svh */
// Timing counts and mode codes for the frame trigger logic.
// Assumes a 40 MHz mclk; included by the package and design files.
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH
`define FTS_CLK_MHZ        40
`define FTS_LATENCY_US     60
`define FTS_LATENCY_CYC    (`FTS_LATENCY_US * `FTS_CLK_MHZ)
`define FTS_PULSE_US       150
`define FTS_PULSE_CYC      (`FTS_PULSE_US * `FTS_CLK_MHZ)
`define FTS_LOW_SETUP_NS   50
`define FTS_HIGH_WIDTH_NS  50
`define FTS_FREE_PERIOD_CYC 40000
`define FTS_CNT_W          20
`define FTS_MODE_MANUAL    2'h0
`define FTS_MODE_HW        2'h1
`define FTS_MODE_FREE      2'h2
`endif

/* fts_pkg.sv */
// Types for the frame trigger logic.
// Assumes fts_cfg.svh is on the include path.
`include "fts_cfg.svh"
package fts_pkg;
	typedef enum logic [1:0] {
		FTS_MANUAL = `FTS_MODE_MANUAL,
		FTS_HW     = `FTS_MODE_HW,
		FTS_FREE   = `FTS_MODE_FREE
	} fts_mode_t;

	typedef enum logic [3:0] {
		FTS_IDLE    = 4'h1,
		FTS_WAIT    = 4'h2,
		FTS_CAPTURE = 4'h4,
		FTS_PULSE   = 4'h8
	} fts_state_t;

	typedef struct packed {
		fts_mode_t  mode;
		logic       out_enable;
	} fts_cfg_t;

	typedef struct packed {
		logic [2:0] sync;
		logic       level;
	} fts_sync_st_t;

	typedef struct packed {
		fts_state_t         state;
		logic [`FTS_CNT_W-1:0] cnt;
		logic [`FTS_CNT_W-1:0] free_cnt;
		fts_cfg_t           cfg;
		logic               capture_start;
		logic               trigger_out;
		logic               cfg_rd_valid;
		fts_cfg_t           cfg_rd;
	} fts_st_t;
endpackage

/* fts_sync.sv */
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the input is asynchronous to mclk.
module fts_sync (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Pin and result
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	fts_pkg::fts_sync_st_t st;
	fts_pkg::fts_sync_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[1:0], pin};
		// Change level only once stages two and three agree
		if (st.sync[1] == st.sync[2])
			next_st.level = st.sync[2];
		if (!rstn)
			next_st = '0;
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	assign level = st.level;
	assign rise  = next_st.level & ~st.level & rstn;
endmodule

/* fts_top.sv */
// Frame trigger logic: trigger input edge detect, capture latency, output pulse.
// Assumes config writes come from the control interface logic on mclk.
`include "fts_cfg.svh"
module fts_top #(
	parameter int LATENCY_CYC = `FTS_LATENCY_CYC,
	parameter int PULSE_CYC   = `FTS_PULSE_CYC,
	parameter int FREE_CYC    = `FTS_FREE_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// Trigger pins
	input  wire logic              trigger_in,
	output logic                   trigger_out,
	// Capture engine
	output logic                   capture_start,
	input  wire logic              capture_done,
	// Configuration access
	input  wire logic              cfg_wr,
	input  wire fts_pkg::fts_cfg_t cfg_wdata,
	input  wire logic              cfg_rd,
	output fts_pkg::fts_cfg_t      cfg_rdata,
	output logic                   cfg_rvalid
);
	localparam logic [`FTS_CNT_W-1:0] LAT_M1  = `FTS_CNT_W'(LATENCY_CYC - 1);
	localparam logic [`FTS_CNT_W-1:0] PUL_M1  = `FTS_CNT_W'(PULSE_CYC - 1);
	localparam logic [`FTS_CNT_W-1:0] FREE_M1 = `FTS_CNT_W'(FREE_CYC - 1);

	fts_pkg::fts_st_t st;
	fts_pkg::fts_st_t next_st;
	logic             trig_level;
	logic             trig_rise;

	fts_sync u_sync (
		.mclk  (mclk),
		.rstn  (rstn),
		.pin   (trigger_in),
		.level (trig_level),
		.rise  (trig_rise)
	);

	always_comb begin
		next_st = st;
		next_st.capture_start = 1'b0;
		next_st.cfg_rd_valid  = 1'b0;
		if (cfg_wr)
			next_st.cfg = cfg_wdata;
		if (cfg_rd) begin
			next_st.cfg_rd       = st.cfg;
			next_st.cfg_rd_valid = 1'b1;
		end
		// Free-run frame timer, held clear in other modes
		if (st.cfg.mode == fts_pkg::FTS_FREE) begin
			if (st.free_cnt == FREE_M1)
				next_st.free_cnt = '0;
			else
				next_st.free_cnt = st.free_cnt + 1'b1;
		end else begin
			next_st.free_cnt = '0;
		end
		case (st.state)
			fts_pkg::FTS_IDLE: begin
				// Edges outside hardware mode are dropped
				if (trig_rise && st.cfg.mode == fts_pkg::FTS_HW) begin
					next_st.state = fts_pkg::FTS_WAIT;
					next_st.cnt   = '0;
				end else if (st.cfg.mode == fts_pkg::FTS_FREE && st.free_cnt == FREE_M1) begin
					next_st.state         = fts_pkg::FTS_CAPTURE;
					next_st.capture_start = 1'b1;
				end
			end
			fts_pkg::FTS_WAIT: begin
				if (st.cnt == LAT_M1) begin
					next_st.state         = fts_pkg::FTS_CAPTURE;
					next_st.capture_start = 1'b1;
				end else begin
					next_st.cnt = st.cnt + 1'b1;
				end
			end
			fts_pkg::FTS_CAPTURE: begin
				if (capture_done) begin
					next_st.cnt = '0;
					if (st.cfg.out_enable) begin
						next_st.state       = fts_pkg::FTS_PULSE;
						next_st.trigger_out = 1'b1;
					end else begin
						next_st.state = fts_pkg::FTS_IDLE;
					end
				end
			end
			fts_pkg::FTS_PULSE: begin
				if (st.cnt == PUL_M1) begin
					next_st.trigger_out = 1'b0;
					next_st.state       = fts_pkg::FTS_IDLE;
				end else begin
					next_st.cnt = st.cnt + 1'b1;
				end
			end
			default: begin
				next_st.state       = fts_pkg::FTS_IDLE;
				next_st.trigger_out = 1'b0;
			end
		endcase
		if (!rstn) begin
			next_st       = '0;
			next_st.state = fts_pkg::FTS_IDLE;
			next_st.cfg.mode = fts_pkg::FTS_MANUAL;
			next_st.cfg.out_enable = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	assign trigger_out   = st.trigger_out;
	assign capture_start = st.capture_start;
	assign cfg_rdata     = st.cfg_rd;
	assign cfg_rvalid    = st.cfg_rd_valid;
endmodule

/* fts_chk_sva.sv */
// Port assertions for the frame trigger logic.
// Assumes one mclk domain with synchronous rstn.
module fts_chk #(parameter int LATENCY_CYC = 8, PULSE_CYC = 10, FREE_CYC = 20) (
	// Watched ports
	input wire logic              mclk, rstn, trigger_in, trigger_out, capture_start, capture_done,
	input wire logic              cfg_wr, cfg_rd, cfg_rvalid,
	input wire fts_pkg::fts_cfg_t cfg_wdata, cfg_rdata
);
	localparam int LMAX = LATENCY_CYC + 6, FMAX = FREE_CYC + PULSE_CYC + 16;
	fts_pkg::fts_cfg_t c;
	logic [19:0]       hi, gap;
	wire               hw = c.mode == fts_pkg::FTS_HW;
	wire               fr = c.mode == fts_pkg::FTS_FREE;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge mclk) begin
		c <= rstn ? (cfg_wr ? cfg_wdata : c) : '0;
		hi <= rstn && trigger_out ? hi + 20'h00001 : 20'h00000;
		gap <= rstn && fr && !capture_start ? gap + 20'h00001 : 20'h00000;
	end
	sequence s_arm; $rose(trigger_in) && hw && !trigger_out; endsequence
	property p_lat; s_arm |-> ##[LATENCY_CYC:LMAX] capture_start; endproperty
	a_lat: assert property (p_lat) else $error("late start");
	property p_one; capture_start |=> !capture_start; endproperty
	a_one: assert property (p_one) else $error("long start");
	// Start was decided on the mode held one edge earlier
	property p_mode; capture_start |-> $past(hw) || $past(fr); endproperty
	a_mode: assert property (p_mode) else $error("stray start");
	property p_wid; $fell(trigger_out) |-> hi == PULSE_CYC; endproperty
	a_wid: assert property (p_wid) else $error("pulse width");
	property p_rise; $rose(trigger_out) |-> $past(capture_done) && $past(c.out_enable); endproperty
	a_rise: assert property (p_rise) else $error("stray pulse");
	property p_chain; $rose(trigger_out) |=> trigger_out[*2]; endproperty
	a_chain: assert property (p_chain) else $error("short pulse");
	property p_rd; cfg_rd |=> cfg_rvalid && cfg_rdata == $past(c); endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_free; fr |-> gap <= FMAX; endproperty
	a_free: assert property (p_free) else $error("free stall");
endmodule
bind fts_top fts_chk #(.LATENCY_CYC(LATENCY_CYC), .PULSE_CYC(PULSE_CYC), .FREE_CYC(FREE_CYC)) u_chk (.*);

/* fts_src.sv */
// Trigger source and capture engine model.
// Assumes mclk is the 40 MHz clock.
module fts_src (
	// Engine and pin
	input  wire logic mclk,
	input  wire logic capture_start,
	output logic      capture_done,
	output logic      trigger_in = 1'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] d = 2'h0;
	always @(posedge mclk) d <= {d[0], capture_start === 1'h1};
	assign capture_done = d[1];
	task automatic fire();
		repeat (4) @(posedge mclk);
		trigger_in <= 1'h1;
		repeat (4) @(posedge mclk);
		trigger_in <= 1'h0;
	endtask
endmodule

/* fts_top_test.sv */
// Self-checking bench for the frame trigger logic.
// Assumes fts_src drives the trigger pin and capture done.
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module fts_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic              mclk = 1'h0, rstn = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0;
	logic              trigger_in, trigger_out, capture_start, capture_done, cfg_rvalid;
	fts_pkg::fts_cfg_t cfg_wdata = '0, cfg_rdata;
	int                err_count = 0, check_count = 0, starts = 0, n;
	fts_top #(.LATENCY_CYC(8), .PULSE_CYC(10), .FREE_CYC(20)) u_dut (.*);
	fts_src u_src (.*);
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk) starts += capture_start;
	task automatic print_verdict();
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(fts_pkg::fts_mode_t m, logic e);
		@(posedge mclk);
		cfg_wr <= 1'h1;
		cfg_wdata <= '{m, e};
		@(posedge mclk);
		cfg_wr <= 1'h0;
	endtask
	task automatic rd(fts_pkg::fts_mode_t m, logic e);
		@(posedge mclk);
		cfg_rd <= 1'h1;
		@(posedge mclk);
		cfg_rd <= 1'h0;
		@(negedge mclk);
		`CK({cfg_rvalid, cfg_rdata}, {1'h1, m, e})
	endtask
	task automatic await(ref logic s);
		for (n = 0; n < 40 && s !== 1'h1; n++) @(negedge mclk);
		if (n == 40) begin err_count++; print_verdict(); end
	endtask
	task automatic t_idle();
		rd(fts_pkg::FTS_MANUAL, 1'h0);
		u_src.fire();
		repeat (30) @(negedge mclk);
		`CK(starts, 0)
	endtask
	task automatic t_hw_off();
		wr(fts_pkg::FTS_HW, 1'h0);
		u_src.fire();
		await(capture_start);
		repeat (30) @(negedge mclk);
		`CK({starts, trigger_out}, {32'h1, 1'h0})
	endtask
	task automatic t_hw_on();
		wr(fts_pkg::FTS_HW, 1'h1);
		rd(fts_pkg::FTS_HW, 1'h1);
		u_src.fire();
		await(trigger_out);
		for (n = 0; trigger_out === 1'h1 && n < 99; n++) @(negedge mclk);
		`CK(n, 10)
	endtask
	task automatic t_reset();
		@(posedge mclk);
		rstn <= 1'h0;
		repeat (4) @(posedge mclk);
		rstn <= 1'h1;
		@(negedge mclk);
		`CK({trigger_out, capture_start, cfg_rvalid}, 3'h0)
		rd(fts_pkg::FTS_MANUAL, 1'h0);
	endtask
	task automatic t_free();
		wr(fts_pkg::FTS_FREE, 1'h0);
		repeat (200) @(negedge mclk);
		`CK(starts > 5, 1'h1)
		wr(fts_pkg::FTS_MANUAL, 1'h0);
		repeat (2) @(negedge mclk);
		n = starts;
		repeat (100) @(negedge mclk);
		`CK(starts, n)
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'h1;
		t_idle();
		t_hw_off();
		t_hw_on();
		t_reset();
		t_free();
		print_verdict();
	end
endmodule
